// ===== core/dod_map.svh
// opcode patterns, field positions and cycle counts for the decoder
`ifndef DOD_MAP_SVH
`define DOD_MAP_SVH
`define DOD_HI_SUB_BORROW   8'h64
`define DOD_HI_SUB_UNSIGNED 8'h66
`define DOD_HI_SUB_VSHIFT   8'h67
`define DOD_HI_XOR_MEM      8'h6c
`define DOD_HI_ZERO_LDRND   8'h68
`define DOD_HI_AUX_ADD      8'h78
`define DOD_HI_AUX_SUB      8'h7c
`define DOD_HI_PAGE_LOAD    8'h0d
`define DOD_HI_ACC_MAPPED   8'h88
`define DOD_HI_JUMP         8'h79
`define DOD_HI_JUMP_D       8'h7d
`define DOD_HI_JNZ          8'h7b
`define DOD_HI_JNZ_D        8'h7f
`define DOD_HI_CALL         8'h7a
`define DOD_HI_CALL_D       8'h7e
`define DOD_TOP5_AUX_STORE  5'h10
`define DOD_TOP12_XOR_LSH   12'hbfd
`define DOD_TOP14_AUX_CMP   14'h2fd1
`define DOD_TOP13_AUX_LDL   13'h17e1
`define DOD_OP_XOR_SH16     16'hbe83
`define DOD_OP_ZERO_AP      16'hbe59
`define DOD_OP_JUMP_ACC     16'hbe20
`define DOD_OP_JUMP_ACC_D   16'hbe21
`define DOD_OP_SUB_ACC      16'hbe30
`define DOD_OP_SUB_ACC_D    16'hbe3d
`define DOD_OP_INT_RET      16'hbe3a
`define DOD_OP_ACC_RVAR     16'hbe5b
`define DOD_OP_ACC_R16      16'hbe5a
`define DOD_OP_SUB_BK_BOR   16'hbe19
`define DOD_OP_SUB_BK       16'hbe18
`define DOD_OP_ACC_L1       16'hbe09
`define DOD_IND_BIT         7
`define DOD_DELAY_SLOTS     3'h2
`define DOD_CYC_1           3'h1
`define DOD_CYC_2           3'h2
`define DOD_CYC_4           3'h4
`endif

// ===== core/dod_pkg.sv
// types shared by the decoder files
package dod_pkg;
	typedef enum logic [4:0] {
		DOD_NONE        = 5'h00, DOD_SUB_BORROW = 5'h01, DOD_SUB_UNSIGNED = 5'h02,
		DOD_SUB_VSHIFT  = 5'h03, DOD_XOR_MEM    = 5'h04, DOD_XOR_LSH      = 5'h05,
		DOD_XOR_SH16    = 5'h06, DOD_ZERO_LDRND = 5'h07, DOD_ZERO_AP      = 5'h08,
		DOD_AUX_ADD     = 5'h09, DOD_AUX_SUB    = 5'h0a, DOD_AUX_CMP      = 5'h0b,
		DOD_AUX_LOAD    = 5'h0c, DOD_PAGE_LOAD  = 5'h0d, DOD_AUX_STORE    = 5'h0e,
		DOD_JUMP        = 5'h0f, DOD_JUMP_ACC   = 5'h10, DOD_JNZ          = 5'h11,
		DOD_SUB_ACC     = 5'h12, DOD_CALL       = 5'h13, DOD_INT_RET      = 5'h14,
		DOD_ACC_RVAR    = 5'h15, DOD_ACC_R16    = 5'h16, DOD_SUB_BK       = 5'h17,
		DOD_SUB_BK_BOR  = 5'h18, DOD_ACC_L1     = 5'h19, DOD_ACC_MAPPED   = 5'h1a
	} dod_op_t;
	typedef struct packed {
		dod_op_t    op;
		logic       valid;
		logic       two_words;
		logic [2:0] cycles;
		logic       delayed;
		logic       indirect;
		logic [6:0] offset;
		logic [7:0] imm8;
		logic [3:0] shift;
		logic [2:0] aux_sel;
		logic [1:0] cond;
	} dod_dec_t;
endpackage : dod_pkg

// ===== core/dod_classify.sv
// combinational opcode classifier
`timescale 1ns/1ps
`default_nettype none
`include "dod_map.svh"
module dod_classify
	import dod_pkg::*;
(
	input  wire logic [15:0] word,
	output dod_dec_t         dec
);
	always_comb
	begin
		dec           = '0;
		dec.valid     = 1'b1;
		dec.cycles    = `DOD_CYC_1;
		dec.indirect  = word[`DOD_IND_BIT];
		dec.offset    = word[6:0];
		dec.imm8      = word[7:0];
		dec.shift     = word[3:0];
		dec.aux_sel   = word[10:8];
		dec.cond      = word[1:0];
		dec.op        = DOD_NONE;
		if (word[15:11] == `DOD_TOP5_AUX_STORE)
			dec.op = DOD_AUX_STORE;
		else if (word[15:4] == `DOD_TOP12_XOR_LSH)
		begin
			dec.op        = DOD_XOR_LSH;
			dec.two_words = 1'b1;
			dec.cycles    = `DOD_CYC_2;
		end
		else if (word[15:2] == `DOD_TOP14_AUX_CMP)
			dec.op = DOD_AUX_CMP;
		else if (word[15:3] == `DOD_TOP13_AUX_LDL)
		begin
			dec.op        = DOD_AUX_LOAD;
			dec.aux_sel   = word[2:0];
			dec.two_words = 1'b1;
			dec.cycles    = `DOD_CYC_2;
		end
		else
		begin
			unique case (word[15:8])
				`DOD_HI_SUB_BORROW:   dec.op = DOD_SUB_BORROW;
				`DOD_HI_SUB_UNSIGNED: dec.op = DOD_SUB_UNSIGNED;
				`DOD_HI_SUB_VSHIFT:   dec.op = DOD_SUB_VSHIFT;
				`DOD_HI_XOR_MEM:      dec.op = DOD_XOR_MEM;
				`DOD_HI_ZERO_LDRND:   dec.op = DOD_ZERO_LDRND;
				`DOD_HI_AUX_ADD:      dec.op = DOD_AUX_ADD;
				`DOD_HI_AUX_SUB:      dec.op = DOD_AUX_SUB;
				`DOD_HI_ACC_MAPPED:   dec.op = DOD_ACC_MAPPED;
				`DOD_HI_PAGE_LOAD:
				begin
					dec.op     = DOD_PAGE_LOAD;
					dec.cycles = `DOD_CYC_2;
				end
				`DOD_HI_JUMP, `DOD_HI_JUMP_D:
				begin
					dec.op        = DOD_JUMP;
					dec.two_words = 1'b1;
					dec.delayed   = word[10];
					dec.cycles    = word[10] ? `DOD_CYC_2 : `DOD_CYC_4;
				end
				`DOD_HI_JNZ, `DOD_HI_JNZ_D:
				begin
					dec.op        = DOD_JNZ;
					dec.two_words = 1'b1;
					dec.delayed   = word[10];
					dec.cycles    = `DOD_CYC_2;
				end
				`DOD_HI_CALL, `DOD_HI_CALL_D:
				begin
					dec.op        = DOD_CALL;
					dec.two_words = 1'b1;
					dec.delayed   = word[10];
					dec.cycles    = word[10] ? `DOD_CYC_2 : `DOD_CYC_4;
				end
				default:
				begin
					unique case (word)
						`DOD_OP_XOR_SH16:
						begin
							dec.op        = DOD_XOR_SH16;
							dec.two_words = 1'b1;
							dec.cycles    = `DOD_CYC_2;
						end
						`DOD_OP_ZERO_AP:    dec.op = DOD_ZERO_AP;
						`DOD_OP_JUMP_ACC:
						begin
							dec.op     = DOD_JUMP_ACC;
							dec.cycles = `DOD_CYC_4;
						end
						`DOD_OP_JUMP_ACC_D:
						begin
							dec.op      = DOD_JUMP_ACC;
							dec.delayed = 1'b1;
							dec.cycles  = `DOD_CYC_2;
						end
						`DOD_OP_SUB_ACC:
						begin
							dec.op     = DOD_SUB_ACC;
							dec.cycles = `DOD_CYC_4;
						end
						`DOD_OP_SUB_ACC_D:
						begin
							dec.op      = DOD_SUB_ACC;
							dec.delayed = 1'b1;
							dec.cycles  = `DOD_CYC_2;
						end
						`DOD_OP_INT_RET:
						begin
							dec.op     = DOD_INT_RET;
							dec.cycles = `DOD_CYC_4;
						end
						`DOD_OP_ACC_RVAR:   dec.op = DOD_ACC_RVAR;
						`DOD_OP_ACC_R16:    dec.op = DOD_ACC_R16;
						`DOD_OP_SUB_BK:     dec.op = DOD_SUB_BK;
						`DOD_OP_SUB_BK_BOR: dec.op = DOD_SUB_BK_BOR;
						`DOD_OP_ACC_L1:     dec.op = DOD_ACC_L1;
						default:            dec.valid = 1'b0;
					endcase
				end
			endcase
		end
	end
endmodule : dod_classify
`default_nettype wire

// ===== core/dod_stage.sv
// one registered stage of a decoded instruction
`timescale 1ns/1ps
`default_nettype none
module dod_stage
	import dod_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     reset,
	input  wire logic     load,
	input  wire dod_dec_t d,
	output dod_dec_t      q
);
	always_ff @(posedge clk)
	begin
		if (reset)
			q <= '0;
		else if (load)
			q <= d;
	end
endmodule : dod_stage
`default_nettype wire

// ===== core/dod_decoder.sv
// instruction decoder for the accumulator, auxiliary and branch subset
// =====================================================================
// Notes on behaviour
// - 0x64xx: subtract operand and borrow, 1 cycle
// - 0x66xx: subtract unsigned operand, 1 cycle
// - 0x67xx: subtract operand shifted by temp[3:0]
// - xor forms: memory 1 cycle, long 2
// - 0x68xx: zero acc, load high, round
// - 0xbe59: clear accumulator and product, 1 cycle
// - 0x78/0x7c: add/subtract imm8 to aux
// - 0xbf44..47: compare aux, set test flag
// - 0xbf08..0f: load aux long, two words
// - 0x0dxx: load page pointer, 2 cycles
// - 0x80-0x87: store selected aux register
// - 0x79 jump 4 cycles, 0x7d delayed 2
// - jump via acc: 4 cycles, delayed 2
// - aux nonzero jump: 2 or 4, delayed 2
// - call via acc: 4 cycles, delayed 2
// - 0x7a call 4 cycles, 0x7e delayed 2
// - 0xbe3a: interrupt return, enable, 4 cycles
// - 0xbe5b: acc right by temp[3:0]
// - 0xbe5a: acc right 16 if temp[4]=0
// - 0xbe19/0xbe18: subtract backup acc, borrow
// - 0xbe09: acc left one bit
// - 0x88xx: acc low to mapped register
`timescale 1ns/1ps
`default_nettype none
`include "dod_map.svh"
module dod_decoder
	import dod_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        word_valid,
	input  wire logic [15:0] word,
	input  wire logic [15:0] aux_current,
	input  wire logic [4:0]  second_temp_register,
	input  wire logic [8:0]  page_pointer,
	output logic             word_ready,
	output dod_dec_t         dec,
	output logic [15:0]      long_word,
	output logic [15:0]      data_address,
	output logic             start,
	output logic             busy,
	output logic             flow_change,
	output logic             illegal,
	output logic [3:0]       operand_shift,
	output logic             acc_shift_enable
);
	// =================================================================
	// classification and state
	// =================================================================
	typedef enum logic [1:0] {
		DOD_IDLE  = 2'b00,
		DOD_WORD2 = 2'b01,
		DOD_EXEC  = 2'b10
	} dod_state_t;

	dod_dec_t   cls;
	dod_dec_t   held;
	dod_state_t state;
	logic [2:0] cyc_left;
	logic [2:0] slots_left;
	logic       flow_pending;
	logic       take_first;
	logic       take_second;
	logic       nz_taken;

	dod_classify u_classify
	(
		.word (word),
		.dec  (cls)
	);

	assign take_first  = word_valid && word_ready && (state == DOD_IDLE);
	assign take_second = word_valid && (state == DOD_WORD2);
	// aux nonzero jump is taken only when the current aux is nonzero
	assign nz_taken    = (held.op == DOD_JNZ) && !held.delayed && (aux_current != 16'h0000);

	dod_stage u_stage
	(
		.clk   (clk),
		.reset (reset),
		.load  (take_first),
		.d     (cls),
		.q     (held)
	);

	// =================================================================
	// sequencing
	// =================================================================
	always_ff @(posedge clk)
	begin
		if (reset)
			state <= DOD_IDLE;
		else
		begin
			unique case (state)
				DOD_IDLE:
					if (take_first)
						state <= cls.two_words ? DOD_WORD2 : DOD_EXEC;
				DOD_WORD2:
					if (take_second)
						state <= DOD_EXEC;
				DOD_EXEC:
					if (cyc_left == `DOD_CYC_1)
						state <= DOD_IDLE;
				default:
					state <= DOD_IDLE;
			endcase
		end
	end

	// execution cycle counter, from the decoded cycle figure
	always_ff @(posedge clk)
	begin
		if (reset)
			cyc_left <= 3'h0;
		else if (take_first)
			cyc_left <= cls.cycles;
		else if (take_second && nz_taken)
			cyc_left <= `DOD_CYC_4;
		else if (state == DOD_EXEC && cyc_left != 3'h0)
			cyc_left <= cyc_left - 3'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			word_ready <= 1'b1;
		else if (take_first)
			word_ready <= 1'b0;
		else if (state == DOD_EXEC && cyc_left == `DOD_CYC_1)
			word_ready <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			long_word <= 16'h0000;
		else if (take_second)
			long_word <= word;
	end

	// =================================================================
	// decoded outputs
	// =================================================================
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			start   <= 1'b0;
			dec     <= '0;
			illegal <= 1'b0;
		end
		else
		begin
			start   <= (take_first && !cls.two_words) || take_second;
			illegal <= take_first && !cls.valid;
			if (take_first)
				dec <= cls;
			else if (take_second && nz_taken)
				dec.cycles <= `DOD_CYC_4;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			busy <= 1'b0;
		else
			busy <= !(state == DOD_IDLE || (state == DOD_EXEC && cyc_left == `DOD_CYC_1));
	end

	// direct address joins page pointer, indirect uses current aux
	always_ff @(posedge clk)
	begin
		if (reset)
			data_address <= 16'h0000;
		else if (take_first)
			data_address <= cls.indirect ? aux_current : {page_pointer, cls.offset};
	end

	// operand shift from the second temp register, or from the instruction word for the long xor
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			operand_shift    <= 4'h0;
			acc_shift_enable <= 1'b0;
		end
		else if (take_first)
		begin
			unique case (cls.op)
				DOD_SUB_VSHIFT, DOD_ACC_RVAR:
				begin
					operand_shift    <= second_temp_register[3:0];
					acc_shift_enable <= 1'b1;
				end
				DOD_ACC_R16:
				begin
					operand_shift    <= 4'h0;
					acc_shift_enable <= !second_temp_register[4];
				end
				DOD_XOR_LSH:
				begin
					operand_shift    <= cls.shift;
					acc_shift_enable <= 1'b1;
				end
				DOD_ACC_L1, DOD_XOR_SH16:
				begin
					operand_shift    <= 4'h0;
					acc_shift_enable <= 1'b1;
				end
				default:
				begin
					operand_shift    <= 4'h0;
					acc_shift_enable <= 1'b0;
				end
			endcase
		end
	end

	// =================================================================
	// flow change, held back past two slots for delayed forms
	// =================================================================
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flow_pending <= 1'b0;
			slots_left   <= 3'h0;
			flow_change  <= 1'b0;
		end
		else
		begin
			flow_change <= 1'b0;
			// a word taken inside the delay slots uses up one slot
			if (take_first && flow_pending && slots_left != 3'h0)
				slots_left <= slots_left - 3'h1;
			else if (take_first)
			begin
				flow_pending <= (cls.op == DOD_JUMP) || (cls.op == DOD_JUMP_ACC)
					|| (cls.op == DOD_CALL) || (cls.op == DOD_SUB_ACC) || (cls.op == DOD_INT_RET);
				slots_left   <= cls.delayed ? `DOD_DELAY_SLOTS : 3'h0;
			end
			else if (take_second && held.op == DOD_JNZ)
				flow_pending <= (aux_current != 16'h0000);
			else if (state == DOD_EXEC && cyc_left == `DOD_CYC_1 && flow_pending
				&& slots_left == 3'h0)
			begin
				flow_change  <= 1'b1;
				flow_pending <= 1'b0;
			end
		end
	end

	// =================================================================
	// checks
	// =================================================================
	jump_cycles_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_JUMP |=> dec.cycles == 3'h4 && dec.two_words)
		else $error("jump cycle count wrong");
	jump_d_cycles_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_JUMP_D |=> dec.cycles == 3'h2 && dec.delayed)
		else $error("delayed jump cycle count wrong");
	page_load_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_PAGE_LOAD |=> dec.op == DOD_PAGE_LOAD
		&& !busy ##1 busy ##1 !busy)
		else $error("page load not two cycles");
	int_ret_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word == `DOD_OP_INT_RET |=> !busy ##1 busy [*3] ##1 !busy)
		else $error("interrupt return not four cycles");
	sub_borrow_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_SUB_BORROW |=> dec.op == DOD_SUB_BORROW
		&& start && !busy)
		else $error("borrow subtract decode wrong");
	indirect_sel_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[7] && word[15:8] == `DOD_HI_SUB_UNSIGNED
		|=> data_address == $past(aux_current))
		else $error("indirect address not from aux");
	shift_cond_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word == `DOD_OP_ACC_R16 |=> acc_shift_enable == !$past(second_temp_register[4]))
		else $error("conditional shift enable wrong");
	vshift_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_SUB_VSHIFT
		|=> operand_shift == $past(second_temp_register[3:0]))
		else $error("variable shift count wrong");
	aux_load_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:3] == `DOD_TOP13_AUX_LDL |=> state == DOD_WORD2
		&& dec.aux_sel == $past(word[2:0]))
		else $error("long aux load decode wrong");
	xor_long_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:4] == `DOD_TOP12_XOR_LSH
		|=> dec.two_words && dec.cycles == `DOD_CYC_2 && operand_shift == $past(word[3:0]))
		else $error("long xor decode wrong");
	xor_mem_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_XOR_MEM
		|=> dec.op == DOD_XOR_MEM && !dec.two_words && dec.cycles == `DOD_CYC_1)
		else $error("memory xor decode wrong");
	zero_round_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_ZERO_LDRND
		|=> dec.op == DOD_ZERO_LDRND && dec.cycles == `DOD_CYC_1)
		else $error("zero load round decode wrong");
	zero_clear_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word == `DOD_OP_ZERO_AP
		|=> dec.op == DOD_ZERO_AP && start && !busy)
		else $error("zero acc and product decode wrong");
	aux_imm_a: assert property (@(posedge clk) disable iff (reset)
		take_first && (word[15:8] == `DOD_HI_AUX_ADD || word[15:8] == `DOD_HI_AUX_SUB)
		|=> dec.imm8 == $past(word[7:0]) && dec.cycles == `DOD_CYC_1)
		else $error("aux immediate decode wrong");
	aux_cmp_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:2] == `DOD_TOP14_AUX_CMP
		|=> dec.op == DOD_AUX_CMP && dec.cond == $past(word[1:0]))
		else $error("aux compare decode wrong");
	aux_store_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:11] == `DOD_TOP5_AUX_STORE
		|=> dec.op == DOD_AUX_STORE && dec.aux_sel == $past(word[10:8]))
		else $error("aux store decode wrong");
	jnz_taken_a: assert property (@(posedge clk) disable iff (reset)
		take_second && held.op == DOD_JNZ && !held.delayed && aux_current != 16'h0000
		|=> dec.cycles == `DOD_CYC_4)
		else $error("taken aux jump not four cycles");
	call_cycles_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_CALL
		|=> dec.op == DOD_CALL && dec.cycles == `DOD_CYC_4 && !dec.delayed)
		else $error("call cycle count wrong");
	sub_backup_a: assert property (@(posedge clk) disable iff (reset)
		take_first && (word == `DOD_OP_SUB_BK || word == `DOD_OP_SUB_BK_BOR)
		|=> start && !busy && dec.cycles == `DOD_CYC_1)
		else $error("backup subtract decode wrong");
	mapped_store_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word[15:8] == `DOD_HI_ACC_MAPPED
		|=> dec.op == DOD_ACC_MAPPED && (dec.cycles == `DOD_CYC_1 || dec.cycles == `DOD_CYC_2))
		else $error("mapped store decode wrong");
	delay_slot_a: assert property (@(posedge clk) disable iff (reset)
		take_first && word == `DOD_OP_JUMP_ACC_D
		|=> (!flow_change) [*3])
		else $error("delayed jump acted too early");
endmodule : dod_decoder
`default_nettype wire

// ===== verification/dod_prog_mem.sv
// program memory model that feeds instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module dod_prog_mem (
	input  wire logic   clk,
	input  wire logic   word_ready,
	output logic        word_valid,
	output logic [15:0] word
);
	// ==========
	// fetch of one instruction, optional stall before word two
	initial
	begin
		word_valid = 1'b0;
		word       = 16'h0000;
	end
	task automatic send(input logic [15:0] w0, input logic [15:0] w1, input logic two,
		input int slow);
		begin
			word_valid <= 1'b1;
			word       <= w0;
			do @(posedge clk); while (word_ready !== 1'b1);
			if (two)
			begin
				repeat (slow)
				begin
					word_valid <= 1'b0;
					word       <= ~w0;
					@(posedge clk);
				end
				word_valid <= 1'b1;
				word       <= w1;
				@(posedge clk);
			end
			word_valid <= 1'b0;
			word       <= two ? ~w1 : ~w0;
		end
	endtask : send
endmodule : dod_prog_mem
`default_nettype wire

// ===== verification/dsp_opcode_decoder_subset_tb_top.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module dsp_opcode_decoder_subset_tb_top;
	import dod_pkg::*;
	logic        clk                  = 1'b0;
	logic        reset                = 1'b1;
	logic [15:0] aux_current          = 16'h0000;
	logic [4:0]  second_temp_register = 5'h00;
	logic [8:0]  page_pointer         = 9'h000;
	logic        word_valid, word_ready, start, busy, flow_change, illegal, acc_shift_enable;
	logic [15:0] word, long_word, data_address;
	logic [3:0]  operand_shift;
	dod_dec_t    dec;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_flow     = 0;
	int          n_ill      = 0;
	int          cycles     = 0;
	always #50 clk = ~clk;
	dod_decoder dut (.clk(clk), .reset(reset), .word_valid(word_valid), .word(word),
		.aux_current(aux_current), .second_temp_register(second_temp_register),
		.page_pointer(page_pointer), .word_ready(word_ready), .dec(dec),
		.long_word(long_word), .data_address(data_address), .start(start), .busy(busy),
		.flow_change(flow_change), .illegal(illegal), .operand_shift(operand_shift),
		.acc_shift_enable(acc_shift_enable));
	dod_prog_mem mem (.clk(clk), .word_ready(word_ready), .word_valid(word_valid),
		.word(word));
	// ==========
	// pulse counters and hang limit
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (flow_change === 1'b1)
			n_flow <= n_flow + 1;
		if (illegal === 1'b1)
			n_ill <= n_ill + 1;
		if (cycles == 3000)
		begin
			n_mismatch = n_mismatch + 1;
			test_done;
		end
	end
	// ==========
	// compare and report
	task automatic test_done;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask : test_done
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
		begin
			num_checks++;
			if (s !== e)
			begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", name, e, s);
			end
		end
	endtask : chk
	task automatic chk_n(input string name, input int e, input int s);
		begin
			num_checks++;
			if (s != e)
			begin
				n_mismatch++;
				$display("wrong value %s expected %0d seen %0d", name, e, s);
			end
		end
	endtask : chk_n
	// ==========
	// one instruction: fetch, decode fields, busy length, ready again
	task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic two,
		input int slow, input dod_op_t op, input logic [2:0] cyc, input int nbusy);
		int k;
		begin
			@(posedge clk);
			mem.send(w0, w1, two, slow);
			#1;
			k = 0;
			while (start !== 1'b1 && k < 4)
			begin
				@(posedge clk);
				#1;
				k++;
			end
			chk("start", 16'h0001, 16'(start));
			chk("op", 16'(op), 16'(dec.op));
			chk("two words", 16'(two), 16'(dec.two_words));
			if (cyc != 3'h0)
				chk("cycles", 16'(cyc), 16'(dec.cycles));
			if (two)
				chk("long word", w1, long_word);
			k = 0;
			// one-word forms raise busy only a cycle after start
			if (!two)
			begin
				@(posedge clk);
				#1;
			end
			while (busy === 1'b1 && k < 8)
			begin
				@(posedge clk);
				#1;
				k++;
			end
			if (nbusy >= 0)
				chk_n("busy cycles", nbusy, k);
			k = 0;
			while (word_ready !== 1'b1 && k < 8)
			begin
				@(posedge clk);
				#1;
				k++;
			end
			chk("ready", 16'h0001, 16'(word_ready));
		end
	endtask : run
	task automatic op1(input logic [15:0] w0, input dod_op_t op, input logic [2:0] cyc);
		begin
			run(w0, 16'h0000, 1'b0, 0, op, cyc, cyc == 3'h0 ? -1 : int'(cyc) - 1);
		end
	endtask : op1
	task automatic flow_one(input logic [15:0] w0, input dod_op_t op, input logic [2:0] cyc,
		input int nb, input logic dly, input int fl);
		int f;
		begin
			f = n_flow;
			run(w0, 16'h0123, w0[15:12] == 4'h7, 0, op, cyc, nb);
			chk("delayed", 16'(dly), 16'(dec.delayed));
			if (dly)
			begin
				op1(16'hbe09, DOD_ACC_L1, 3'h1);
				chk_n("early flow", f, n_flow);
				op1(16'hbe09, DOD_ACC_L1, 3'h1);
			end
			repeat (3) @(posedge clk);
			chk_n("flow", f + fl, n_flow);
		end
	endtask : flow_one
	// ==========
	// scenarios
	task automatic t_acc;
		begin
			@(posedge clk);
			page_pointer         <= 9'h1a5;
			aux_current          <= 16'h3c5a;
			second_temp_register <= 5'h1b;
			op1(16'h6405, DOD_SUB_BORROW, 3'h1);
			chk("direct address", {9'h1a5, 7'h05}, data_address);
			op1(16'h6685, DOD_SUB_UNSIGNED, 3'h1);
			chk("indirect address", 16'h3c5a, data_address);
			op1(16'h6710, DOD_SUB_VSHIFT, 3'h1);
			chk("shift", 16'h000b, 16'(operand_shift));
			op1(16'hbe19, DOD_SUB_BK_BOR, 3'h1);
			op1(16'hbe18, DOD_SUB_BK, 3'h1);
			op1(16'hbe09, DOD_ACC_L1, 3'h1);
			second_temp_register <= 5'h16;
			op1(16'hbe5b, DOD_ACC_RVAR, 3'h1);
			chk("shift", 16'h0006, 16'(operand_shift));
			op1(16'hbe5a, DOD_ACC_R16, 3'h1);
			chk("shift enable", 16'h0000, 16'(acc_shift_enable));
			second_temp_register <= 5'h06;
			op1(16'hbe5a, DOD_ACC_R16, 3'h1);
			chk("shift enable", 16'h0001, 16'(acc_shift_enable));
			$display("test acc done");
		end
	endtask : t_acc
	task automatic t_xor;
		begin
			op1(16'h6c07, DOD_XOR_MEM, 3'h1);
			run(16'hbfd9, 16'h1234, 1'b1, 0, DOD_XOR_LSH, 3'h2, 2);
			chk("shift", 16'h0009, 16'(operand_shift));
			run(16'hbe83, 16'habcd, 1'b1, 2, DOD_XOR_SH16, 3'h2, 2);
			op1(16'h6811, DOD_ZERO_LDRND, 3'h1);
			op1(16'hbe59, DOD_ZERO_AP, 3'h1);
			$display("test xor done");
		end
	endtask : t_xor
	task automatic t_aux;
		begin
			op1(16'h78a5, DOD_AUX_ADD, 3'h1);
			chk("imm", 16'h00a5, 16'(dec.imm8));
			op1(16'h7c3c, DOD_AUX_SUB, 3'h1);
			chk("imm", 16'h003c, 16'(dec.imm8));
			for (int c = 0; c < 4; c++)
			begin
				op1(16'hbf44 | 16'(c), DOD_AUX_CMP, 3'h1);
				chk("cond", 16'(c), 16'(dec.cond));
			end
			run(16'hbf0d, 16'h55aa, 1'b1, 0, DOD_AUX_LOAD, 3'h2, 2);
			chk("aux select", 16'h0005, 16'(dec.aux_sel));
			op1(16'h0d83, DOD_PAGE_LOAD, 3'h2);
			chk("indirect address", 16'h3c5a, data_address);
			op1(16'h8312, DOD_AUX_STORE, 3'h1);
			chk("aux select", 16'h0003, 16'(dec.aux_sel));
			op1(16'h8822, DOD_ACC_MAPPED, 3'h0);
			$display("test aux done");
		end
	endtask : t_aux
	task automatic t_flow;
		begin
			aux_current <= 16'h0001;
			flow_one(16'h7981, DOD_JUMP, 3'h4, 4, 1'b0, 1);
			flow_one(16'h7d81, DOD_JUMP, 3'h2, 2, 1'b1, 1);
			flow_one(16'hbe20, DOD_JUMP_ACC, 3'h4, 3, 1'b0, 1);
			flow_one(16'hbe21, DOD_JUMP_ACC, 3'h2, 1, 1'b1, 1);
			flow_one(16'h7b81, DOD_JNZ, 3'h0, 4, 1'b0, 1);
			flow_one(16'h7f81, DOD_JNZ, 3'h2, 2, 1'b1, 1);
			flow_one(16'hbe30, DOD_SUB_ACC, 3'h4, 3, 1'b0, 1);
			flow_one(16'hbe3d, DOD_SUB_ACC, 3'h2, 1, 1'b1, 1);
			flow_one(16'h7a81, DOD_CALL, 3'h4, 4, 1'b0, 1);
			flow_one(16'h7e81, DOD_CALL, 3'h2, 2, 1'b1, 1);
			flow_one(16'hbe3a, DOD_INT_RET, 3'h4, 3, 1'b0, 1);
			aux_current <= 16'h0000;
			flow_one(16'h7b81, DOD_JNZ, 3'h0, 2, 1'b0, 0);
			$display("test flow done");
		end
	endtask : t_flow
	task automatic t_ill_reset;
		int f;
		begin
			f = n_ill;
			@(posedge clk);
			mem.send(16'hbe22, 16'h0000, 1'b0, 0);
			repeat (3) @(posedge clk);
			#1;
			chk_n("illegal", f + 1, n_ill);
			chk("ready", 16'h0001, 16'(word_ready));
			@(posedge clk);
			mem.send(16'hbe3a, 16'h0000, 1'b0, 0);
			reset <= 1'b1;
			@(posedge clk);
			#1;
			chk("reset ready", 16'h0001, 16'(word_ready));
			chk("reset busy", 16'h0000, 16'(busy));
			chk("reset valid", 16'h0000, 16'(dec.valid));
			@(posedge clk);
			reset <= 1'b0;
			op1(16'hbe09, DOD_ACC_L1, 3'h1);
			$display("test illegal and reset done");
		end
	endtask : t_ill_reset
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_acc;
		t_xor;
		t_aux;
		t_flow;
		t_ill_reset;
		test_done;
	end
endmodule : dsp_opcode_decoder_subset_tb_top
`default_nettype wire
